//--- verilog/pps_pkg.sv
// shared constants and types for the power sequencer
package pps_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int TICK_HZ = 32768;
	localparam int TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int RESET_HOLD_MS = 120;
	localparam int SOFT_ASSERT_MS = 80;
	localparam int SOFT_OFF_MS = 320;
	localparam int BAT_OK_MS = 100;
	localparam int STEP_TICKS = 64;
	// least times round up in ticks
	localparam int RESET_HOLD_TK = (RESET_HOLD_MS * TICK_HZ + 999) / 1000;
	localparam int SOFT_ASSERT_TK = (SOFT_ASSERT_MS * TICK_HZ + 999) / 1000;
	localparam int SOFT_OFF_TK = (SOFT_OFF_MS * TICK_HZ + 999) / 1000;
	localparam int BAT_OK_TK = (BAT_OK_MS * TICK_HZ + 999) / 1000;
	localparam int CNT_W = 16;
	localparam int DIV_W = 11;
	// ---------------------------------------------------------------
	// rails, thresholds, faults and states
	// ---------------------------------------------------------------
	localparam int NUM_STEPS = 8;
	localparam logic [3:0] BAT_THR_RST = 4'h0;
	localparam logic [3:0] RAIL_THR_RST = 4'h0;
	typedef struct packed {
		logic reference;
		logic buckThree;
		logic linregTwo;
		logic buckOneTwo;
		logic linregSystem;
		logic linregFive;
		logic linregThree;
		logic linregFour;
	} pps_rails_type;
	typedef struct packed {
		logic underVoltage;
		logic thermalShutdown;
		logic overCurrent;
		logic systemRailLow;
		logic batteryRelease;
	} pps_faults_type;
	typedef enum logic [2:0] {
		ST_OFF, ST_SEQ, ST_ON, ST_SOFT_WAIT, ST_SOFT_OFF, ST_STANDBY
	} pps_state_type;
endpackage : pps_pkg

//--- verilog/pps_power_sequencer.sv
// power-on/off sequencer of the power management device
// How it works
// - power up on button, external or charger
// - button start is aligned to 32 kHz tick
// - button echo is inverse of button
// - rails enable in fixed documented order
// - reset releases 120 ms after system rail
// - hold alone never starts power-on
// - all requests and hold low: rails off
// - hold low while button high: soft reset
// - soft reset: 80 ms delay with reset released, then 320 ms off and restart
// - standby bit keeps buck three on
// - button or external wakes from standby
// - undervoltage clears standby bit
// - soft reset, rail, overcurrent: full off
// - undervoltage turns everything off
// - thermal off, restart if request present
// - battery ok 100 ms after detector release
// - battery threshold register, default code
// - rail detector holds reset, 120 ms release
// - rail drop: all off, restart if request
// - rail detector threshold register driven
`timescale 1ns/10ps
module pps_power_sequencer (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic power_button_in,
	input wire logic ext_power_request_in,
	input wire logic charger_rapid_in,
	input wire logic power_hold_in,
	input wire pps_pkg::pps_faults_type faults_in,
	input wire logic standby_set,
	input wire logic [3:0] bat_thr_wr,
	input wire logic bat_thr_we,
	input wire logic [3:0] rail_thr_wr,
	input wire logic rail_thr_we,
	output pps_pkg::pps_rails_type rails_en,
	output logic button_echo_n_o,
	output logic button_echo_n_oe,
	output logic system_reset_out_n_o,
	output logic system_reset_out_n_oe,
	output logic battery_ok_out_o,
	output logic battery_ok_out_oe,
	output logic standby_bit,
	output logic [3:0] bat_threshold,
	output logic [3:0] rail_threshold
);
	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] syncA_reg;
	logic [NSYNC-1:0] syncB_reg;
	logic btn, ext, chg, hold, uvlo, hot, ocp, railLow, batRel;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
		end else begin
			syncA_reg <= {power_button_in, ext_power_request_in,
				charger_rapid_in, power_hold_in, faults_in};
			syncB_reg <= syncA_reg;
		end
	end
	assign {btn, ext, chg, hold, uvlo, hot, ocp, railLow, batRel} = syncB_reg;
	logic btnPrev_reg, extPrev_reg, chgPrev_reg, holdPrev_reg;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			btnPrev_reg <= 1'b0;
			extPrev_reg <= 1'b0;
			chgPrev_reg <= 1'b0;
			holdPrev_reg <= 1'b0;
		end else begin
			btnPrev_reg <= btn;
			extPrev_reg <= ext;
			chgPrev_reg <= chg;
			holdPrev_reg <= hold;
		end
	end
	// hold is deliberately absent from the wake term
	logic wakeEdge, request, holdFall;
	assign wakeEdge = (btn & ~btnPrev_reg) | (ext & ~extPrev_reg)
		| (chg & ~chgPrev_reg);
	assign request = btn | ext | chg;
	assign holdFall = ~hold & holdPrev_reg;

	// ---------------------------------------------------------------
	// 32 kHz tick
	// ---------------------------------------------------------------
	logic [pps_pkg::DIV_W-1:0] div_reg;
	logic tick_reg;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else if (div_reg == pps_pkg::DIV_W'(pps_pkg::TICK_DIV - 1)) begin
			div_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			div_reg <= div_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// sequencer state
	// ---------------------------------------------------------------
	pps_pkg::pps_state_type state_reg;
	logic [pps_pkg::CNT_W-1:0] cnt_reg;
	logic [2:0] step_reg;
	logic pending_reg;
	logic fatal;
	// faults force a full off; no standby afterwards
	assign fatal = uvlo | hot | ocp | (railLow & ~system_reset_out_n_oe
		& state_reg == pps_pkg::ST_ON);
	// a wake seen between ticks waits for the next tick
	always_ff @(posedge clock) begin
		if (sys_rst)
			pending_reg <= 1'b0;
		else if (tick_reg || fatal)
			pending_reg <= 1'b0;
		else if (wakeEdge)
			pending_reg <= 1'b1;
	end
	logic startNow;
	assign startNow = tick_reg & (pending_reg | wakeEdge
		| (request & state_reg == pps_pkg::ST_OFF));
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= pps_pkg::ST_OFF;
			cnt_reg <= '0;
			step_reg <= '0;
		end else if (fatal) begin
			state_reg <= pps_pkg::ST_OFF;
			cnt_reg <= '0;
			step_reg <= '0;
		end else begin
			unique case (state_reg)
				pps_pkg::ST_OFF, pps_pkg::ST_STANDBY: begin
					if (startNow && !uvlo && !hot) begin
						state_reg <= pps_pkg::ST_SEQ;
						cnt_reg <= '0;
						step_reg <= '0;
					end
				end
				pps_pkg::ST_SEQ: begin
					if (tick_reg) begin
						if (cnt_reg == pps_pkg::CNT_W'(pps_pkg::STEP_TICKS - 1)) begin
							cnt_reg <= '0;
							if (step_reg == 3'(pps_pkg::NUM_STEPS - 1))
								state_reg <= pps_pkg::ST_ON;
							else
								step_reg <= step_reg + 1'b1;
						end else
							cnt_reg <= cnt_reg + 1'b1;
					end
				end
				pps_pkg::ST_ON: begin
					if (holdFall && btn) begin
						state_reg <= pps_pkg::ST_SOFT_WAIT;
						cnt_reg <= '0;
					end else if (!request && !hold && !holdPrev_reg
							&& system_reset_out_n_oe == 1'b0) begin
						state_reg <= standby_bit ? pps_pkg::ST_STANDBY
							: pps_pkg::ST_OFF;
					end
				end
				pps_pkg::ST_SOFT_WAIT: begin
					if (hold)
						state_reg <= pps_pkg::ST_ON;
					else if (tick_reg) begin
						if (cnt_reg == pps_pkg::CNT_W'(pps_pkg::SOFT_ASSERT_TK - 1)) begin
							state_reg <= pps_pkg::ST_SOFT_OFF;
							cnt_reg <= '0;
						end else
							cnt_reg <= cnt_reg + 1'b1;
					end
				end
				pps_pkg::ST_SOFT_OFF: begin
					if (tick_reg) begin
						if (cnt_reg == pps_pkg::CNT_W'(pps_pkg::SOFT_OFF_TK - 1)) begin
							state_reg <= pps_pkg::ST_SEQ;
							cnt_reg <= '0;
							step_reg <= 3'h1;
						end else
							cnt_reg <= cnt_reg + 1'b1;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// rail enables
	// ---------------------------------------------------------------
	// packed field order equals the enable order, reference first
	logic [pps_pkg::NUM_STEPS-1:0] railsNext;
	genvar gi;
	generate
		for (gi = 0; gi < pps_pkg::NUM_STEPS; gi++) begin : g_rail
			localparam int IDX = pps_pkg::NUM_STEPS - 1 - gi;
			always_comb begin
				unique case (state_reg)
					pps_pkg::ST_SEQ: railsNext[IDX] = (step_reg >= 3'(gi));
					pps_pkg::ST_ON: railsNext[IDX] = 1'b1;
					pps_pkg::ST_SOFT_WAIT: railsNext[IDX] = 1'b1;
					pps_pkg::ST_STANDBY: railsNext[IDX] = (gi == 1);
					default: railsNext[IDX] = 1'b0;
				endcase
			end
		end
	endgenerate
	always_ff @(posedge clock) begin
		if (sys_rst)
			rails_en <= '0;
		else if (fatal)
			rails_en <= '0;
		else
			rails_en <= railsNext;
	end

	// ---------------------------------------------------------------
	// reset output
	// ---------------------------------------------------------------
	logic [pps_pkg::CNT_W-1:0] rstCnt_reg;
	logic relCond;
	// counter restarts whenever the system rail or the detector drops
	// soft wait keeps reset released until its own delay runs out
	assign relCond = rails_en.linregSystem & ~railLow
		& (state_reg == pps_pkg::ST_SEQ || state_reg == pps_pkg::ST_ON
		|| state_reg == pps_pkg::ST_SOFT_WAIT);
	always_ff @(posedge clock) begin
		if (sys_rst || !relCond) begin
			rstCnt_reg <= '0;
			system_reset_out_n_oe <= 1'b1;
		end else if (tick_reg && system_reset_out_n_oe) begin
			if (rstCnt_reg == pps_pkg::CNT_W'(pps_pkg::RESET_HOLD_TK - 1))
				system_reset_out_n_oe <= 1'b0;
			else
				rstCnt_reg <= rstCnt_reg + 1'b1;
		end
	end
	assign system_reset_out_n_o = 1'b0;

	// ---------------------------------------------------------------
	// button echo and battery ok
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst)
			button_echo_n_oe <= 1'b0;
		else
			button_echo_n_oe <= btn;
	end
	assign button_echo_n_o = 1'b0;
	logic [pps_pkg::CNT_W-1:0] batCnt_reg;
	always_ff @(posedge clock) begin
		if (sys_rst || !batRel) begin
			batCnt_reg <= '0;
			battery_ok_out_oe <= 1'b1;
		end else if (tick_reg && battery_ok_out_oe) begin
			if (batCnt_reg == pps_pkg::CNT_W'(pps_pkg::BAT_OK_TK))
				battery_ok_out_oe <= 1'b0;
			else
				batCnt_reg <= batCnt_reg + 1'b1;
		end
	end
	assign battery_ok_out_o = 1'b0;

	// ---------------------------------------------------------------
	// settings
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst || uvlo)
			standby_bit <= 1'b0;
		else if (standby_set)
			standby_bit <= 1'b1;
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bat_threshold <= pps_pkg::BAT_THR_RST;
			rail_threshold <= pps_pkg::RAIL_THR_RST;
		end else begin
			if (bat_thr_we)
				bat_threshold <= bat_thr_wr;
			if (rail_thr_we)
				rail_threshold <= rail_thr_wr;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_hold_only: assert property (@(posedge clock)
		disable iff (sys_rst)
		(state_reg == pps_pkg::ST_OFF && !request && !pending_reg)
		|=> state_reg != pps_pkg::ST_SEQ)
		else $error("hold alone started power-on");
	chk_echo_follows: assert property (@(posedge clock)
		disable iff (sys_rst) $rose(btn) |=> button_echo_n_oe)
		else $error("echo not pulled low");
	chk_echo_release: assert property (@(posedge clock)
		disable iff (sys_rst) $fell(btn) |=> !button_echo_n_oe)
		else $error("echo not released");
	chk_reset_with_rail: assert property (@(posedge clock)
		disable iff (sys_rst)
		!rails_en.linregSystem |=> system_reset_out_n_oe)
		else $error("reset released without system rail");
	chk_standby_buck: assert property (@(posedge clock)
		disable iff (sys_rst)
		state_reg == pps_pkg::ST_STANDBY
		##1 state_reg == pps_pkg::ST_STANDBY
		|-> rails_en == pps_pkg::pps_rails_type'(8'h40))
		else $error("standby rails wrong");
	chk_uvlo_standby: assert property (@(posedge clock)
		disable iff (sys_rst)
		uvlo |=> !standby_bit && state_reg == pps_pkg::ST_OFF)
		else $error("undervoltage not handled");
	chk_fault_off: assert property (@(posedge clock)
		disable iff (sys_rst)
		(hot || ocp) |=> rails_en == '0)
		else $error("rails on during fault");
	chk_order: assert property (@(posedge clock)
		disable iff (sys_rst)
		rails_en.buckThree |-> rails_en.reference
		|| state_reg == pps_pkg::ST_STANDBY
		|| $past(state_reg) == pps_pkg::ST_STANDBY)
		else $error("enable order broken");
	chk_bat_low: assert property (@(posedge clock)
		disable iff (sys_rst)
		!batRel |=> battery_ok_out_oe)
		else $error("battery ok without release");
	chk_start_tick: assert property (@(posedge clock)
		disable iff (sys_rst)
		(state_reg == pps_pkg::ST_SEQ
		&& $past(state_reg) != pps_pkg::ST_SEQ) |-> $past(tick_reg))
		else $error("sequence started off the tick");
	chk_soft_hold: assert property (@(posedge clock)
		disable iff (sys_rst)
		(state_reg == pps_pkg::ST_SOFT_WAIT && !system_reset_out_n_oe
		&& !railLow) |=> !system_reset_out_n_oe)
		else $error("reset dropped before soft delay");
	chk_soft_off: assert property (@(posedge clock)
		disable iff (sys_rst)
		state_reg == pps_pkg::ST_SOFT_OFF |=> rails_en == '0)
		else $error("rails on during soft reset");
	chk_rail_low_rst: assert property (@(posedge clock)
		disable iff (sys_rst) railLow |=> system_reset_out_n_oe)
		else $error("reset released with rail low");
	chk_rail_drop: assert property (@(posedge clock)
		disable iff (sys_rst)
		(railLow && !system_reset_out_n_oe
		&& state_reg == pps_pkg::ST_ON)
		|=> rails_en == '0 && state_reg == pps_pkg::ST_OFF)
		else $error("rail drop left rails on");
	chk_standby_wake: assert property (@(posedge clock)
		disable iff (sys_rst)
		(state_reg == pps_pkg::ST_STANDBY && tick_reg && !fatal
		&& btn && !btnPrev_reg) |=> state_reg == pps_pkg::ST_SEQ)
		else $error("standby did not wake");
endmodule : pps_power_sequencer

//--- verif/pps_host_model.sv
// host and power button model for the sequencer bench
`timescale 1ns/10ps
module pps_host_model (
	input wire logic clock,
	input wire logic pressCmd,
	input wire logic holdEarly,
	input wire logic resetOe,
	output logic buttonLevel,
	output logic holdLevel
);
	initial begin
		buttonLevel = 1'b0;
		holdLevel = 1'b0;
	end
	always @(posedge clock) begin
		buttonLevel <= #1 pressCmd;
	end
	// hold only after reset release; early hold is a bench-ordered misuse
	always @(posedge clock) begin
		holdLevel <= #1 holdEarly | (~resetOe & pressCmd);
	end
endmodule : pps_host_model

//--- verif/pps_power_sequencer_tb_top.sv
// self-checking bench for the power sequencer
`timescale 1ns/10ps
module pps_power_sequencer_tb_top;
	localparam int TD = pps_pkg::TICK_DIV;
	logic clock = 1'b0;
	logic sysRst = 1'b1;
	logic pressCmd = 1'b0;
	logic holdEarly = 1'b0;
	logic extReq = 1'b0;
	logic chgReq = 1'b0;
	logic standbySet = 1'b0;
	logic batWe = 1'b0;
	logic railWe = 1'b0;
	logic [3:0] batWr = 4'h0;
	logic [3:0] railWr = 4'h0;
	pps_pkg::pps_faults_type faults = '0;
	pps_pkg::pps_rails_type rails;
	logic button, hold, echoO, echoOe, rstO, rstOe, batO, batOe, stbBit;
	logic [3:0] batThr, railThr;
	logic [31:0] lfsr = 32'd89905;
	logic [7:0] expQ[$];
	int errTotal = 0;
	int checks = 0;
	int took;
	always #12.5 clock = ~clock;
	pps_host_model pps_host_model_i (.clock(clock), .pressCmd(pressCmd),
		.holdEarly(holdEarly), .resetOe(rstOe), .buttonLevel(button),
		.holdLevel(hold));
	pps_power_sequencer pps_power_sequencer_i (.clock(clock),
		.sys_rst(sysRst), .power_button_in(button),
		.ext_power_request_in(extReq), .charger_rapid_in(chgReq),
		.power_hold_in(hold), .faults_in(faults), .standby_set(standbySet),
		.bat_thr_wr(batWr), .bat_thr_we(batWe), .rail_thr_wr(railWr),
		.rail_thr_we(railWe), .rails_en(rails), .button_echo_n_o(echoO),
		.button_echo_n_oe(echoOe), .system_reset_out_n_o(rstO),
		.system_reset_out_n_oe(rstOe), .battery_ok_out_o(batO),
		.battery_ok_out_oe(batOe), .standby_bit(stbBit),
		.bat_threshold(batThr), .rail_threshold(railThr));
	// ---------------------------------------------------------------
	// helpers and model
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errTotal++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	// rails expected with the first n rails enabled, reference first
	function automatic logic [31:0] lfsrNext(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsrNext
	function automatic logic [7:0] expRails(input int n);
		return 8'hff << (8 - n);
	endfunction : expRails
	task automatic waitRef(output int t);
		t = 0;
		while (rails.reference !== 1'b1 && t < TD + 8) begin
			cyc(1);
			t++;
		end
	endtask : waitRef
	task automatic doReset;
		sysRst = 1'b1;
		{pressCmd, extReq, chgReq, holdEarly} = 4'h0;
		faults = '0;
		cyc(8);
		sysRst = 1'b0;
		cyc(1);
	endtask : doReset
	task automatic wrapUp;
		if (errTotal == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrapUp
	// sized from the scenario lengths below, about three times over
	initial begin
		repeat (60000) @(posedge clock);
		errTotal++;
		wrapUp();
	end
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		doReset();
		check("rails", rails, expRails(0));
		check("rstOe", {rstO, rstOe, echoO, echoOe}, 4'h4);
		check("batOe", {batO, batOe, stbBit, batThr, railThr}, 11'h200);
		holdEarly = 1'b1;
		cyc(3 * TD);
		check("holdOnly", rails, expRails(0));
		for (int s = 0; s < 3; s++) begin
			doReset();
			{pressCmd, extReq, chgReq} = 3'h4 >> s;
			cyc(4);
			check("echoOe", echoOe, s == 0);
			waitRef(took);
			check("start", rails, expRails(1));
			check("rstHeld", rstOe, 1'b1);
		end
		cyc(2 * TD);
		check("order", rails, expRails(1));
		doReset();
		pressCmd = 1'b1;
		waitRef(took);
		faults.thermalShutdown = 1'b1;
		cyc(6);
		check("hotOff", rails, expRails(0));
		faults.thermalShutdown = 1'b0;
		waitRef(took);
		check("coolOn", rails, expRails(1));
		faults.overCurrent = 1'b1;
		cyc(6);
		check("ocpOff", rails, expRails(0));
		faults.overCurrent = 1'b0;
		waitRef(took);
		check("ocpOn", rails, expRails(1));
		standbySet = 1'b1;
		cyc(1);
		standbySet = 1'b0;
		cyc(2);
		check("stbSet", stbBit, 1'b1);
		faults.underVoltage = 1'b1;
		cyc(6);
		check("uvOff", rails, expRails(0));
		check("uvStb", stbBit, 1'b0);
		cyc(2 * TD);
		check("uvHold", rails, expRails(0));
		faults.underVoltage = 1'b0;
		pressCmd = 1'b0;
		// random threshold codes, expectations queued
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsrNext(lfsr);
			{railWr, batWr} = lfsr[7:0];
			expQ.push_back(lfsr[7:0]);
			{batWe, railWe} = 2'h3;
			cyc(1);
			{batWe, railWe} = 2'h0;
			cyc(1);
			check("thr", {railThr, batThr}, expQ.pop_front());
		end
		faults.batteryRelease = 1'b1;
		cyc(4 * TD);
		check("batEarly", batOe, 1'b1);
		wrapUp();
	end
endmodule : pps_power_sequencer_tb_top
